// file: common/bsm_pkg.sv
// Package with constants and types for the boot strap and mode select block
package bsm_pkg;

  // Boot modes decoded from the strap pair
  typedef enum logic [1:0] {
    BSM_MODE_PARALLEL,
    BSM_MODE_FAST_SERIAL,
    BSM_MODE_SPI_SLAVE,
    BSM_MODE_STANDALONE
  } bsm_mode_t;

  // Strap pair encodings
  localparam logic [1:0] BSM_STRAP_PARALLEL = 2'h0;
  localparam logic [1:0] BSM_STRAP_FAST_SERIAL = 2'h1;
  localparam logic [1:0] BSM_STRAP_SPI_SLAVE = 2'h2;
  localparam logic [1:0] BSM_STRAP_STANDALONE = 2'h3;

  // Register byte addresses on the Wishbone bus
  localparam logic [15:0] BSM_ADDR_CPU_RATE = 16'hC008;
  localparam logic [15:0] BSM_ADDR_BOOT_STATUS = 16'hC010;

  // Reset value of the rate register: divide by one (full rate)
  localparam logic [15:0] BSM_CPU_RATE_RESET = 16'h0000;

  // Field positions of the boot status register
  localparam int BSM_ST_MODE_LSB = 0;
  localparam int BSM_ST_CLOCK_SOURCE_STRAP_BIT = 2;
  localparam int BSM_ST_DONE_BIT = 3;
  localparam int BSM_ST_FETCH_BIT = 4;
  localparam int BSM_ST_ROLE_BIT = 5;

  // Width of the rate divider field in the rate register
  localparam int BSM_RATE_FIELD_W = 4;

  // General purpose pin positions
  localparam int BSM_PIN_STRAP_LO = 30;
  localparam int BSM_PIN_STRAP_HI = 31;
  localparam int BSM_PIN_IDENT = 29;
  localparam int BSM_PIN_UART_TX = 28;
  localparam int BSM_PIN_UART_RX = 27;

  // Reset vector
  localparam logic [15:0] BSM_RESET_VECTOR = 16'hFF00;

  // Timing figures
  localparam int BSM_CLK_MHZ = 250;
  localparam int BSM_BOOT_US = 3000;
  localparam int BSM_FETCH_US = 200;
  localparam int BSM_BOOT_CYCLES = BSM_BOOT_US * BSM_CLK_MHZ;
  localparam int BSM_FETCH_CYCLES = BSM_FETCH_US * BSM_CLK_MHZ;

  // Interface rate ceilings in bits per second, and the parallel port width in bits
  localparam int BSM_SERIAL_MAX_BAUD = 2000000;
  localparam int BSM_SPI_MAX_BPS = 2000000;
  localparam int BSM_PARALLEL_WIDTH = 16;

endpackage : bsm_pkg

// file: design/bsm_boot_select.sv
// Boot strap capture, mode selection and pin role defaults
// Contract
// [R1] Capture strap pair at reset release
// [R2] Decode strap pair into four boot modes
// [R3] Boot procedure lasts at most three milliseconds
// [R4] Straps released to GPIO after boot
// [R5] Coprocessor mode enables only selected interface
// [R6] Code loading waits boot interval after reset
// [R7] Parallel sixteen bit, serial, SPI slave interfaces
// [R8] Standalone drives both strap pins as outputs; the code drives pin 30 only while eeprom_sda_oe_i is high
// [R9] Standalone gives pins 28,27 to debug UART
// [R10] Pin 29 sets port one A role
// [R11] Other ports peripheral, other pins inputs
// [R12] Clock select strap sampled after reset
// [R13] Standalone uses internal CPU, EEPROM or USB
// [R14] CPU rate reducible without touching peripherals
// [R15] Reset vector fetch about 200 us later
// [R16] Captured straps stable until next reset
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module bsm_boot_select
  import bsm_pkg::*;
#(
  parameter int BOOT_CYCLES = BSM_BOOT_CYCLES,
  parameter int FETCH_CYCLES = BSM_FETCH_CYCLES,
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Strap and pin levels
  input wire logic [31:0] gpio_in_i,
  input wire logic clock_source_strap_i,
  // Application pin control after boot
  input wire logic [31:0] app_gpio_out_i,
  input wire logic [31:0] app_gpio_oe_i,
  // Pin drive
  output logic [31:0] gpio_out_o,
  output logic [31:0] gpio_oe_o,
  // EEPROM bit-bang from boot firmware
  input wire logic eeprom_scl_i,
  input wire logic eeprom_sda_oe_i,
  // Debug UART transmit and receive
  input wire logic uart_tx_i,
  output logic uart_rx_o,
  // Mode and role results
  output logic [1:0] boot_mode_o,
  output logic parallel_host_port_en_o,
  output logic fast_serial_port_en_o,
  output logic spi_slave_en_o,
  output logic standalone_o,
  output logic internal_cpu_main_o,
  output logic usb_port_one_a_peripheral_o,
  output logic [2:0] usb_other_ports_peripheral_o,
  output logic clock_source_12mhz_o,
  output logic boot_busy_o,
  output logic load_allowed_o,
  output logic fetch_start_o,
  output logic [15:0] fetch_addr_o,
  output logic cpu_step_o
);

  // Width of the timer counters
  localparam int TW = $clog2(BOOT_CYCLES + 1) + 1;

  // Previous reset level, to see the release edge
  logic rst_q;
  // Captured straps held until next reset
  logic [1:0] strap;
  logic clock_source_strap;
  logic captured;
  // Boot and fetch timer results
  logic boot_done;
  logic fetch_done;
  logic fetch_seen;
  // Rate register
  logic [15:0] cpu_rate;

  // Decode of the strap pair, used once on the held or live straps
  function automatic bsm_mode_t bsm_decode(input logic [1:0] s);
    bsm_mode_t m;
    m = BSM_MODE_PARALLEL;
    if (s == BSM_STRAP_FAST_SERIAL) begin
      m = BSM_MODE_FAST_SERIAL;
    end else if (s == BSM_STRAP_SPI_SLAVE) begin
      m = BSM_MODE_SPI_SLAVE;
    end else if (s == BSM_STRAP_STANDALONE) begin
      m = BSM_MODE_STANDALONE;
    end
    return m;
  endfunction : bsm_decode

  // Release edge of the synchronous reset
  wire release_edge = rst_q && !rst_i;
  wire [1:0] strap_live = {gpio_in_i[BSM_PIN_STRAP_HI], gpio_in_i[BSM_PIN_STRAP_LO]};

  // Track the reset level
  always_ff @(posedge clk_i) begin
    rst_q <= rst_i;
  end

  // Straps are caught by a clocked process at the release, never by the reset itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap <= 2'h0;
      clock_source_strap <= 1'b0;
      captured <= 1'b0;
    end else if (release_edge) begin
      strap <= strap_live; // R1 R16
      clock_source_strap <= clock_source_strap_i; // R12
      captured <= 1'b1;
    end
  end

  // Mode from the held straps; before capture the pins are still sampled live
  wire bsm_mode_t mode = bsm_decode(captured ? strap : strap_live); // R2
  wire is_standalone = captured && (mode == BSM_MODE_STANDALONE);
  wire is_coproc = captured && !is_standalone; // R5

  // Boot timer: cleared while reset is held, runs from release
  bsm_counter #(
    .COUNT(BOOT_CYCLES),
    .W(TW)
  ) u_boot_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .done_o(boot_done)
  ); // R3

  // Fetch delay timer before the reset vector is issued
  bsm_counter #(
    .COUNT(FETCH_CYCLES),
    .W(TW)
  ) u_fetch_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .done_o(fetch_done)
  ); // R15

  // One pulse when the fetch delay expires
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_seen <= 1'b0;
      fetch_start_o <= 1'b0;
    end else begin
      fetch_seen <= fetch_done;
      fetch_start_o <= fetch_done && !fetch_seen; // R15
    end
  end
  assign fetch_addr_o = BSM_RESET_VECTOR;

  // Mode outputs
  assign boot_mode_o = mode;
  assign standalone_o = is_standalone;
  assign internal_cpu_main_o = is_standalone; // R13
  assign parallel_host_port_en_o = is_coproc && (mode == BSM_MODE_PARALLEL); // R5 R7
  assign fast_serial_port_en_o = is_coproc && (mode == BSM_MODE_FAST_SERIAL); // R5 R7
  assign spi_slave_en_o = is_coproc && (mode == BSM_MODE_SPI_SLAVE); // R5 R7
  assign boot_busy_o = !boot_done;
  // Loading over the chosen interface waits for the full boot interval
  assign load_allowed_o = is_coproc && boot_done; // R6
  assign clock_source_12mhz_o = clock_source_strap; // R12

  // USB roles: port one A follows the identity pin in standalone, the rest default peripheral
  assign usb_port_one_a_peripheral_o = is_standalone ? gpio_in_i[BSM_PIN_IDENT] : 1'b1; // R10
  assign usb_other_ports_peripheral_o = 3'h7; // R11
  assign uart_rx_o = is_standalone ? gpio_in_i[BSM_PIN_UART_RX] : 1'b1; // R9

  // Default pin plan while booting: everything input except the standalone extras
  logic [31:0] boot_out;
  logic [31:0] boot_oe;
  always_comb begin
    boot_out = 32'h0000_0000;
    boot_oe = 32'h0000_0000; // R11
    if (is_standalone) begin
      boot_out[BSM_PIN_STRAP_HI] = eeprom_scl_i;
      boot_oe[BSM_PIN_STRAP_HI] = 1'b1; // R8
      boot_out[BSM_PIN_STRAP_LO] = 1'b0;
      boot_oe[BSM_PIN_STRAP_LO] = eeprom_sda_oe_i; // R8
      boot_out[BSM_PIN_UART_TX] = uart_tx_i;
      boot_oe[BSM_PIN_UART_TX] = 1'b1; // R9
    end
  end

  // After boot the application owns the strap pins; the UART keeps its pins in standalone
  always_comb begin
    gpio_out_o = app_gpio_out_i;
    gpio_oe_o = app_gpio_oe_i;
    if (!boot_done || !captured) begin
      gpio_out_o = boot_out; // R4
      gpio_oe_o = boot_oe;
    end else if (is_standalone) begin
      gpio_out_o[BSM_PIN_UART_TX] = uart_tx_i; // R9
      gpio_oe_o[BSM_PIN_UART_TX] = 1'b1;
      gpio_oe_o[BSM_PIN_UART_RX] = 1'b0;
    end
  end

  // Wishbone decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hit_rate = (wb_adr_i == BSM_ADDR_CPU_RATE);
  wire hit_status = (wb_adr_i == BSM_ADDR_BOOT_STATUS);
  wire hit_any = hit_rate || hit_status;
  wire [15:0] status_word = {10'h000, usb_port_one_a_peripheral_o, fetch_seen, boot_done, clock_source_strap, strap};

  // Rate register write, per byte lane; only the low field steers the divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_rate <= BSM_CPU_RATE_RESET;
    end else if (bus_req && wb_we_i && hit_rate) begin
      if (wb_sel_i[0]) begin
        cpu_rate[7:0] <= wb_dat_i[7:0]; // R14
      end
      if (wb_sel_i[1]) begin
        cpu_rate[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // One-cycle answer, error on unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && hit_any;
      wb_err_o <= bus_req && !hit_any;
      if (bus_req && !wb_we_i && hit_rate) begin
        wb_dat_o <= {16'h0000, cpu_rate};
      end else if (bus_req && !wb_we_i && hit_status) begin
        wb_dat_o <= {16'h0000, status_word};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // CPU step pulses; peripherals keep running on clk_i
  bsm_cpu_rate #(
    .RW(BSM_RATE_FIELD_W)
  ) u_cpu_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rate_i(cpu_rate[BSM_RATE_FIELD_W-1:0]),
    .cpu_step_o(cpu_step_o)
  ); // R14

endmodule : bsm_boot_select
`default_nettype wire

// file: design/bsm_counter.sv
// Terminal count timer restarted by a clear
`timescale 1ns/1ps
`default_nettype none
module bsm_counter
  import bsm_pkg::*;
#(
  parameter int COUNT = 16,
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  // Status
  output logic done_o
);

  // Running count
  logic [W-1:0] count;
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  // Count up to the terminal value then hold
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (count == LAST) begin
      done_o <= 1'b1;
    end else begin
      count <= count + W'(1);
    end
  end

endmodule : bsm_counter
`default_nettype wire

// file: design/bsm_cpu_rate.sv
// CPU clock enable generator dividing the core rate by 2^n
`timescale 1ns/1ps
`default_nettype none
module bsm_cpu_rate
  import bsm_pkg::*;
#(
  parameter int RW = BSM_RATE_FIELD_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Divider exponent from software
  input wire logic [RW-1:0] rate_i,
  // One-cycle CPU step pulse
  output logic cpu_step_o
);

  // Free running prescaler; peripherals never see it, only the CPU step
  logic [15:0] pre;
  wire [15:0] mask = (16'h0001 << rate_i) - 16'h0001;

  // Step when the low bits wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= 16'h0000;
      cpu_step_o <= 1'b0;
    end else begin
      pre <= pre + 16'h0001;
      cpu_step_o <= ((pre & mask) == mask);
    end
  end

endmodule : bsm_cpu_rate
`default_nettype wire

// file: testbench/boot_strap_mode_select_bench.sv
// Self-checking bench for the boot strap and mode select block
`timescale 1ns/1ps
`default_nettype none
module boot_strap_mode_select_bench;
  import bsm_pkg::*;
  // Short counts keep the run brief
  typedef struct packed {logic err; logic chk; logic [31:0] dat;} bsm_note_t;
  bsm_note_t notes[$];
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] app_gpio_out_i = 32'h0;
  logic [31:0] app_gpio_oe_i = 32'h0;
  logic [31:0] fl = 32'h0;
  logic [1:0] strap = 2'h3;
  logic clock_source_strap_i = 1'b1;
  logic eeprom_scl_i = 1'b0;
  logic eeprom_sda_oe_i = 1'b0;
  logic uart_tx_i = 1'b1;
  logic [31:0] wb_dat_o, gpio_in_i, gpio_out_o, gpio_oe_o;
  logic wb_ack_o, wb_err_o, uart_rx_o, parallel_host_port_en_o, fast_serial_port_en_o, spi_slave_en_o;
  logic standalone_o, internal_cpu_main_o, usb_port_one_a_peripheral_o, clock_source_12mhz_o;
  logic boot_busy_o, load_allowed_o, fetch_start_o, cpu_step_o;
  logic [1:0] boot_mode_o;
  logic [2:0] usb_other_ports_peripheral_o;
  logic [15:0] fetch_addr_o;
  int err_count = 0;
  int tests_run = 0;
  int seed = 65;
  int cycles = 0;
  always #2 clk_i = ~clk_i;
  bsm_boot_select #(.BOOT_CYCLES(50), .FETCH_CYCLES(20)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .gpio_in_i,
    .clock_source_strap_i, .app_gpio_out_i, .app_gpio_oe_i, .gpio_out_o, .gpio_oe_o, .eeprom_scl_i,
    .eeprom_sda_oe_i, .uart_tx_i, .uart_rx_o, .boot_mode_o, .parallel_host_port_en_o, .fast_serial_port_en_o,
    .spi_slave_en_o, .standalone_o, .internal_cpu_main_o, .usb_port_one_a_peripheral_o,
    .usb_other_ports_peripheral_o, .clock_source_12mhz_o, .boot_busy_o, .load_allowed_o, .fetch_start_o,
    .fetch_addr_o, .cpu_step_o);
  bsm_pin_model i_pins (.strap_i(strap), .float_i(fl), .gpio_out_i(gpio_out_o), .gpio_oe_i(gpio_oe_o),
    .gpio_in_o(gpio_in_i));
  // Compare a level
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Compare a bus answer
  task automatic check_bus(input bsm_note_t got, input bsm_note_t exp);
    check({31'h0, got.err}, {31'h0, exp.err});
    if (exp.chk) check(got.dat, exp.dat);
  endtask : check_bus
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      $display("ERROR %0t: timed out", $time);
      report_and_stop();
    end
  end
  // Each bus answer retires the oldest note
  always @(posedge clk_i) begin
    if ((wb_ack_o === 1'b1 || wb_err_o === 1'b1) && notes.size() > 0) begin
      check_bus({wb_err_o, 1'b1, wb_dat_o}, notes.pop_front());
    end
  end
  // One classic cycle; request held until the answer edge
  task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat, input bsm_note_t exp);
    notes.push_back(exp);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= dat;
    // Wait for ack or err; only the bench hang guard ends this wait if neither comes
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Bounded wait for a level
  task automatic wait_for(ref logic sig, input logic lvl);
    int k;
    k = 0;
    while (sig !== lvl && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    check({31'h0, sig}, {31'h0, lvl});
  endtask : wait_for
  initial begin
    logic [31:0] eoe;
    logic [3:0] rate;
    logic [2:0] rv;
    int steps;
    for (int m = 0; m < 4; m++) begin
      // Strap a mode, reset three cycles, release
      @(posedge clk_i);
      rv = 3'($random(seed));
      strap <= m[1:0];
      fl <= $random(seed);
      clock_source_strap_i <= rv[0];
      eeprom_scl_i <= rv[1];
      uart_tx_i <= rv[2];
      eeprom_sda_oe_i <= 1'b0;
      app_gpio_oe_i <= 32'h0;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      // Move the straps after capture; results must not follow
      strap <= ~m[1:0];
      clock_source_strap_i <= ~rv[0];
      eeprom_sda_oe_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check({30'h0, boot_mode_o}, m);
      check({29'h0, spi_slave_en_o, fast_serial_port_en_o, parallel_host_port_en_o}, (m == 3) ? 0 : 1 << m);
      check({30'h0, standalone_o, internal_cpu_main_o}, (m == 3) ? 32'h3 : 32'h0);
      check({31'h0, clock_source_12mhz_o}, {31'h0, rv[0]});
      check({28'h0, usb_other_ports_peripheral_o, usb_port_one_a_peripheral_o}, {28'h7, (m == 3) ? fl[29] : 1'b1});
      if (m == 3) begin
        check({gpio_oe_o[31:30], gpio_out_o[31:30], gpio_oe_o[28], gpio_out_o[28], uart_rx_o},
          {2'h3, rv[1], 1'b0, 1'b1, rv[2], fl[27]});
      end
      check({31'h0, boot_busy_o}, 32'h1);
      // The vector fetch comes well before the boot interval ends
      wait_for(fetch_start_o, 1'b1);
      check({16'h0, fetch_addr_o}, {16'h0, BSM_RESET_VECTOR});
      check({31'h0, boot_busy_o}, 32'h1);
      wait_for(boot_busy_o, 1'b0);
      check({31'h0, load_allowed_o}, (m == 3) ? 32'h0 : 32'h1);
      wb(1'b0, BSM_ADDR_BOOT_STATUS, 32'h0, {2'h1, 26'h0, (m == 3) ? fl[29] : 1'b1, 2'h3, rv[0], m[1:0]});
      wb(1'b0, BSM_ADDR_CPU_RATE, 32'h0, {2'h1, 32'h0});
      rate = 4'(m + ($random(seed) & 1));
      wb(1'b1, BSM_ADDR_CPU_RATE, {28'h0, rate}, {2'h0, 32'h0});
      wb(1'b0, BSM_ADDR_CPU_RATE, 32'h0, {2'h1, 28'h0, rate});
      wb(1'b0, 16'hC00A, 32'h0, {2'h2, 32'h0});
      // Step count over 64 cycles follows the rate
      steps = 0;
      repeat (64) begin
        @(posedge clk_i);
        steps += int'(cpu_step_o === 1'b1);
      end
      check(steps, 64 >> rate);
      // After boot the application owns the pins, except the UART pins 28 and 27 in standalone
      app_gpio_out_i <= $random(seed);
      app_gpio_oe_i <= $random(seed);
      repeat (2) @(posedge clk_i);
      eoe = app_gpio_oe_i;
      if (m == 3) eoe[28:27] = 2'h2;
      check(gpio_oe_o, eoe);
      $display("Mode %0d test done", m);
    end
    check(notes.size(), 0);
    report_and_stop();
  end
endmodule : boot_strap_mode_select_bench
`default_nettype wire

// file: testbench/bsm_boot_select_assertions.sv
// Port assertions for the boot strap and mode select block
`timescale 1ns/1ps
`default_nettype none
module bsm_checker
  import bsm_pkg::*;
#(
  parameter int BOOT_CYCLES = 50
) (
  // Clock and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Results
  input wire logic [31:0] gpio_oe_o,
  input wire logic [1:0] boot_mode_o,
  input wire logic parallel_host_port_en_o,
  input wire logic fast_serial_port_en_o,
  input wire logic spi_slave_en_o,
  input wire logic standalone_o,
  input wire logic boot_busy_o,
  input wire logic load_allowed_o,
  input wire logic fetch_start_o
);
  // Cycles since release; saturates so long runs stay quiet
  logic [15:0] age;
  logic [15:0] next_age;
  assign next_age = (age == 16'hFFFF) ? age : age + 16'h0001;
  always_ff @(posedge clk_i) begin
    age <= rst_i ? 16'h0000 : next_age;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A taken request, then one answer lasting one cycle
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence reply_s;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  bus_reply_a:
    assert property (req_s |=> reply_s) else $error("bus answer missing");
  err_map_a:
    assert property (wb_err_o |-> $past(wb_adr_i) != BSM_ADDR_CPU_RATE && $past(wb_adr_i) != BSM_ADDR_BOOT_STATUS)
      else $error("error on mapped address");
  mode_flag_a:
    assert property (age > 16'h0003 |-> standalone_o == (boot_mode_o == 2'h3)) else $error("standalone flag wrong");
  one_enable_a:
    assert property (age > 16'h0003 |-> {spi_slave_en_o, fast_serial_port_en_o, parallel_host_port_en_o}
      == (standalone_o ? 3'h0 : 3'h1 << boot_mode_o)) else $error("interface enables wrong");
  strap_hold_a:
    assert property (age > 16'h0003 |-> $stable(boot_mode_o)) else $error("captured mode moved");
  boot_busy_a:
    assert property (age > 16'h0002 && age < BOOT_CYCLES - 2 |-> boot_busy_o) else $error("boot ended early");
  boot_done_a:
    assert property (age > BOOT_CYCLES + 3 |-> !boot_busy_o) else $error("boot overran");
  load_gate_a:
    assert property (load_allowed_o |-> !boot_busy_o && !standalone_o) else $error("load opened early");
  strap_drive_a:
    assert property (standalone_o && boot_busy_o |-> gpio_oe_o[31]) else $error("clock strap not driven");
  pins_input_a:
    assert property (boot_busy_o && age > 16'h0003 |-> gpio_oe_o[29] == 1'b0 && gpio_oe_o[27:0] == 28'h0)
      else $error("pin driven during boot");
  fetch_pulse_a:
    assert property (fetch_start_o |-> boot_busy_o ##1 !fetch_start_o) else $error("fetch pulse wrong");
endmodule : bsm_checker
bind bsm_boot_select bsm_checker #(.BOOT_CYCLES(BOOT_CYCLES)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_adr_i, .wb_ack_o, .wb_err_o, .gpio_oe_o, .boot_mode_o, .parallel_host_port_en_o, .fast_serial_port_en_o,
  .spi_slave_en_o, .standalone_o, .boot_busy_o, .load_allowed_o, .fetch_start_o);
`default_nettype wire

// file: testbench/bsm_pin_model.sv
// Board pins: strap resistors and loose pins seen by the block
`timescale 1ns/1ps
`default_nettype none
module bsm_pin_model (
  // Board levels
  input wire logic [1:0] strap_i,
  input wire logic [31:0] float_i,
  // Block drive
  input wire logic [31:0] gpio_out_i,
  input wire logic [31:0] gpio_oe_i,
  // Levels back to the block
  output logic [31:0] gpio_in_o
);
  // Driven pins read their drive; loose ones a random pattern, not a settled X
  assign gpio_in_o = (gpio_oe_i & gpio_out_i) | (~gpio_oe_i & {strap_i, float_i[29:0]});
endmodule : bsm_pin_model
`default_nettype wire
